// ### test/cps_stage_model.sv
// Purpose: Flyback power stage as seen through the auxiliary winding
// Assumes: Bench sets the analogue targets after a rising edge
// Notes:   Estimates lag one clock; burst start every 64 clocks in burst
`timescale 1ns/100ps
`default_nettype none
module cps_stage_model (
    input wire logic i_clk,              // clock
    input wire logic [11:0] i_vout,      // output voltage target
    input wire logic [11:0] i_vin,       // input voltage target
    input wire logic [11:0] i_vcc,       // supply target
    input wire logic [1:0] i_mode,       // switching mode
    input wire logic i_demag,            // demag too short
    output var logic [11:0] o_vout_est,  // output estimate
    output var logic [11:0] o_vin_est,   // input estimate
    output var logic [11:0] o_vcc_lvl,   // supply code
    output var logic [1:0] o_mode,       // mode seen by block
    output var logic o_demag,            // demag flag
    output var logic o_burst_start       // burst start pulse
);
    logic [5:0] burst_cnt_r = 6'h00;
    // Defined values from time zero so the block never sees unknowns
    initial begin
        {o_vout_est, o_vin_est, o_vcc_lvl, o_mode, o_demag, o_burst_start} = 41'h0;
    end
    always @(posedge i_clk) begin
        o_vout_est <= i_vout;
        o_vin_est <= i_vin;
        o_vcc_lvl <= i_vcc;
        o_mode <= i_mode;
        o_demag <= i_demag;
        burst_cnt_r <= burst_cnt_r + 6'h01;
        o_burst_start <= (i_mode == 2'h2) && (burst_cnt_r == 6'h3F);
    end
endmodule // cps_stage_model
`default_nettype wire

// ### test/cps_supervisor_props.sv
// Purpose: Port assertions for cps_supervisor
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Phase 0 lockout, 1 precheck, 3 regulated, 4 restart wait, 5 latch
`timescale 1ns/100ps
`default_nettype none
module cps_supervisor_props #(
    parameter P_OP_CYC_CLKS = 640
) (
    input wire logic I_MCLK,            // clock
    input wire logic I_RST_N,           // reset, active low
    input wire logic I_CE,              // clock enable
    input wire logic I_PSEL,            // APB select
    input wire logic I_PENABLE,         // APB enable
    input wire logic [1:0] I_MODE,      // switching mode
    input wire logic O_PREADY,          // APB ready
    input wire logic O_PSLVERR,         // APB error
    input wire logic O_GATE_EN,         // gate driver enable
    input wire logic [2:0] O_PHASE,     // supervisor phase
    input wire logic [3:0] O_FAULT_CODE // last fault
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    apb_ready_a: assert property (I_CE && I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (I_CE && O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    fault_gate_a: assert property ($changed(O_FAULT_CODE) && O_FAULT_CODE != 4'h0 |-> !O_GATE_EN)
        else $error("gate still on at fault");
    fault_react_a: assert property ($changed(O_FAULT_CODE) && O_FAULT_CODE != 4'h0 |-> O_PHASE inside {3'h4, 3'h5})
        else $error("fault without reaction");
    fixed_restart_a: assert property ($changed(O_FAULT_CODE) && O_FAULT_CODE inside {4'h2, [4'h4:4'h9]}
        |-> O_PHASE == 3'h4) else $error("fixed fault did not restart");
    latch_hold_a: assert property (O_PHASE == 3'h5 |=> O_PHASE inside {3'h0, 3'h5})
        else $error("latch left without lockout");
    lockout_exit_a: assert property (O_PHASE == 3'h0 |-> !O_GATE_EN ##1 O_PHASE <= 3'h1)
        else $error("lockout left wrongly");
    precheck_short_a: assert property (I_CE && O_PHASE == 3'h1 |=> O_PHASE != 3'h1)
        else $error("precheck longer than one cycle");
    burst_quiet_a: assert property ($changed(O_FAULT_CODE) && O_FAULT_CODE inside {4'h3, 4'h4}
        |-> $past(I_MODE) != 2'h2) else $error("output check ran in burst");
    halt_gate_a: assert property (O_PHASE inside {3'h4, 3'h5} |-> !O_GATE_EN)
        else $error("gate on while halted");
endmodule // cps_supervisor_props
`default_nettype wire

// ### test/cps_supervisor_tb_top.sv
// Purpose: Self-checking bench for cps_supervisor
// Assumes: Operation cycle shortened to 640 clocks, tick every 10
// Notes:   Phase waits are bounded and allow for tick alignment
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.vh"
module cps_supervisor_tb_top;
    localparam int OPC = 640;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic err;
    logic [11:0] vout = 12'h1F4;
    logic [11:0] vin = 12'h1F4;
    logic [11:0] vcc = 12'h000;
    logic [1:0] mode = 2'h0;
    logic demag = 1'b0;
    logic ce = 1'b1;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire gate;
    wire [2:0] phase;
    wire [3:0] fcode;
    wire [11:0] vo_e;
    wire [11:0] vi_e;
    wire [11:0] vc_e;
    wire [1:0] md_e;
    wire dm_e;
    wire bs_e;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] cad [7] = '{`CPS_A_OLVL, `CPS_A_ILVL, `CPS_A_SLVL, `CPS_A_VLVL, `CPS_A_MLVL, `CPS_A_TIM0, `CPS_A_TIM1};
    logic [31:0] cfg [7] = '{32'h0320_0064, 32'h0384_00C8, 32'h0320_012C, 32'h0400_0600,
                             32'h0190_0100, 32'h0101_0102, 32'h0000_0202};

    always #4 clk = ~clk;

    cps_stage_model u_stage (.i_clk(clk), .i_vout(vout), .i_vin(vin), .i_vcc(vcc), .i_mode(mode), .i_demag(demag),
        .o_vout_est(vo_e), .o_vin_est(vi_e), .o_vcc_lvl(vc_e), .o_mode(md_e), .o_demag(dm_e), .o_burst_start(bs_e));
    cps_supervisor #(.P_OP_CYC_CLKS(OPC)) dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_VOUT_EST(vo_e), .I_VIN_EST(vi_e), .I_VCC_LVL(vc_e),
        .I_MODE(md_e), .I_DEMAG_SHORT(dm_e), .I_BURST_START(bs_e), .O_GATE_EN(gate), .O_PHASE(phase),
        .O_FAULT_CODE(fcode));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Gate runs in startup and regulated only
    task automatic st(input logic [2:0] p, input logic [3:0] f);
        chk({24'h0, gate, phase, fcode}, {24'h0, p inside {3'h2, 3'h3}, p, f});
    endtask
    task automatic go(input logic [2:0] p, input logic [3:0] f, input int lim);
        int n = 0;
        while (phase !== p && n < lim) begin
            @(posedge clk);
            n++;
        end
        st(p, f);
    endtask
    // No cycle count is assumed: the access lasts until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(`CPS_A_CTRL, `CPS_RST_VAL, 1'b0);
        rd(`CPS_A_STAT, `CPS_RST_VAL, 1'b0);
        apb(1'b1, `CPS_A_CTRL, 32'hFFFF_FFFF);
        rd(`CPS_A_CTRL, `CPS_CTRL_MASK, 1'b0);
        apb(1'b1, `CPS_A_STAT, 32'hFFFF_FFFF);
        rd(`CPS_A_STAT, `CPS_RST_VAL, 1'b0);
        apb(1'b1, 8'h40, 32'h1234_5678);
        chk({31'h0, err}, 32'h0000_0001);
        rd(8'h40, 32'h0000_0000, 1'b1);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, cad[i], cfg[i]);
            rd(cad[i], cfg[i], 1'b0);
        end
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0017);
    endtask
    task automatic t_power();
        vcc <= 12'h500;
        cyc(30);
        st(3'h0, 4'h0);
        vcc <= 12'h700;
        go(3'h3, 4'h0, 3000);
        vcc <= 12'h500;
        cyc(30);
        st(3'h3, 4'h0);
        vcc <= 12'h700;
    endtask
    task automatic t_oov();
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0057);
        vout <= 12'h384;
        cyc(100);
        vout <= 12'h1F4;
        cyc(20);
        vout <= 12'h384;
        cyc(140);
        st(3'h3, 4'h0);
        go(3'h5, `CPS_F_OOV, 60);
        vout <= 12'h1F4;
        cyc(800);
        st(3'h5, `CPS_F_OOV);
        vcc <= 12'h300;
        go(3'h0, `CPS_F_OOV, 20);
        vcc <= 12'h700;
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0017);
        go(3'h3, `CPS_F_OOV, 3000);
    endtask
    task automatic t_burst();
        mode <= 2'h2;
        vout <= 12'h384;
        demag <= 1'b1;
        cyc(800);
        st(3'h3, `CPS_F_OOV);
        vout <= 12'h1F4;
        demag <= 1'b0;
        cyc(2);
        mode <= 2'h0;
    endtask
    task automatic t_demag();
        demag <= 1'b1;
        cyc(300);
        st(3'h3, `CPS_F_OOV);
        go(3'h4, `CPS_F_DEMAG, 1000);
        demag <= 1'b0;
        go(3'h3, `CPS_F_DEMAG, 4000);
    endtask
    task automatic t_ouv();
        vout <= 12'h032;
        cyc(600);
        st(3'h3, `CPS_F_DEMAG);
        go(3'h4, `CPS_F_OUV, 800);
        go(3'h2, `CPS_F_OUV, 1000);
        cyc(1800);
        st(3'h2, `CPS_F_OUV);
        go(3'h4, `CPS_F_SOUV, 1000);
        vout <= 12'h1F4;
        go(3'h3, `CPS_F_SOUV, 4000);
    endtask
    task automatic t_pre();
        // Enable low must freeze the phase even though supply dropped
        ce <= 1'b0;
        vcc <= 12'h300;
        cyc(40);
        st(3'h3, `CPS_F_SOUV);
        ce <= 1'b1;
        go(3'h0, `CPS_F_SOUV, 20);
        vin <= 12'h064;
        vcc <= 12'h700;
        go(3'h4, `CPS_F_PMIN, 20);
        vin <= 12'h352;
        go(3'h1, `CPS_F_PMIN, 1000);
        go(3'h4, `CPS_F_PMAX, 5);
        vin <= 12'h1F4;
        go(3'h3, `CPS_F_PMAX, 4000);
    endtask
    task automatic t_iov();
        mode <= 2'h1;
        vin <= 12'h3B6;
        cyc(600);
        st(3'h3, `CPS_F_PMAX);
        go(3'h4, `CPS_F_IOV, 100);
        vin <= 12'h1F4;
        mode <= 2'h0;
        go(3'h3, `CPS_F_IOV, 4000);
    endtask
    task automatic t_iuv();
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0015);
        vin <= 12'h096;
        cyc(7000);
        st(3'h3, `CPS_F_IOV);
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0017);
        cyc(6000);
        st(3'h3, `CPS_F_IOV);
        go(3'h4, `CPS_F_IUV, 800);
        vin <= 12'h1F4;
        go(3'h3, `CPS_F_IUV, 4000);
    endtask
    // Supply minimum above the off level so the check can trip
    task automatic t_suv();
        apb(1'b1, `CPS_A_MLVL, 32'h0190_0500);
        apb(1'b1, `CPS_A_CTRL, 32'h0000_001F);
        vcc <= 12'h480;
        cyc(500);
        st(3'h3, `CPS_F_IUV);
        go(3'h4, `CPS_F_SUV, 1000);
        vcc <= 12'h700;
        go(3'h3, `CPS_F_SUV, 4000);
    endtask
    task automatic t_bin();
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0007);
        mode <= 2'h2;
        vin <= 12'h3B6;
        cyc(800);
        st(3'h3, `CPS_F_SUV);
        apb(1'b1, `CPS_A_CTRL, 32'h0000_0017);
        go(3'h4, `CPS_F_IOV, 200);
        vin <= 12'h1F4;
        mode <= 2'h0;
        go(3'h3, `CPS_F_IOV, 4000);
    endtask

    task automatic close_out();
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        cyc(16);
        rst_n <= 1'b1;
        t_regs();
        t_power();
        t_oov();
        t_burst();
        t_demag();
        t_ouv();
        t_pre();
        t_iov();
        t_iuv();
        t_suv();
        t_bin();
        close_out();
    end
    // Whole run needs about 30000 clocks; give up after 60000
    initial begin
        #480000;
        num_errors++;
        close_out();
    end
endmodule // cps_supervisor_tb_top

bind cps_supervisor cps_supervisor_props #(.P_OP_CYC_CLKS(P_OP_CYC_CLKS)) u_props (.I_MCLK(I_MCLK),
    .I_RST_N(I_RST_N), .I_CE(I_CE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_MODE(I_MODE),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_GATE_EN(O_GATE_EN), .O_PHASE(O_PHASE),
    .O_FAULT_CODE(O_FAULT_CODE));
`default_nettype wire

// ### verilog/cps_blank.v
// Purpose: Blanking timer that qualifies one fault condition
// Assumes: step is a one-cycle pulse in the timer's time base
// Notes:   Fires once the condition has held for limit steps
`timescale 1ns/100ps
`default_nettype none
module cps_blank (
    input wire i_clk,          // clock
    input wire i_rst_n,        // sync reset, active low
    input wire i_ce,           // clock enable
    input wire i_cond,         // fault condition present
    input wire i_step,         // time base step
    input wire [15:0] i_limit, // steps to blank
    output wire o_fire         // blanking expired
);
    reg [15:0] cnt_r;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r <= 16'h0000;
        end else if (i_ce) begin
            if (!i_cond) begin
                cnt_r <= 16'h0000;
            end else if (i_step && (cnt_r < i_limit)) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    assign o_fire = i_cond && (cnt_r >= i_limit);
endmodule // cps_blank
`default_nettype wire

// ### verilog/cps_regs.vh
// Purpose: Constants of the converter protection supervisor
// Assumes: 32-bit APB register file, 125 MHz clock
// Notes:   Offsets are byte addresses; levels are 12-bit codes
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CPS_A_CTRL 8'h00
`define CPS_A_OLVL 8'h04
`define CPS_A_ILVL 8'h08
`define CPS_A_SLVL 8'h0C
`define CPS_A_VLVL 8'h10
`define CPS_A_MLVL 8'h14
`define CPS_A_TIM0 8'h18
`define CPS_A_TIM1 8'h1C
`define CPS_A_STAT 8'h20

// ----------------------------------------
// Fields
// ----------------------------------------
`define CPS_B_OUV_EN 0
`define CPS_B_IUV_EN 1
`define CPS_B_IOV_EN 2
`define CPS_B_SUV_EN 3
`define CPS_B_BIP_EN 4
`define CPS_B_OUV_LAT 5
`define CPS_B_OOV_LAT 6
`define CPS_LO 11:0
`define CPS_HI 27:16
`define CPS_T_B0 7:0
`define CPS_T_B1 15:8
`define CPS_T_B2 23:16
`define CPS_T_B3 31:24
`define CPS_CTRL_MASK 32'h0000_007F
`define CPS_LVL_MASK 32'h0FFF_0FFF
`define CPS_T1_MASK 32'h0000_FFFF
`define CPS_RST_VAL 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CPS_CLK_NS 8
`define CPS_OP_CYC_NS 1000000
`define CPS_TICKS_PER_OP 64
`define CPS_OP_SHIFT 6'h06
`define CPS_OOV_TICKS 16'h0010
`define CPS_DEMAG_TICKS 7'h20
`define CPS_IUV_TICKS 16'h0280
`define CPS_IOV_TICKS 16'h0040
`define CPS_START_PER_CAP 8'h04
`define CPS_SUB_LAST 6'h3F

// ----------------------------------------
// Modes and fault codes
// ----------------------------------------
`define CPS_MODE_BURST 2'h2
`define CPS_F_NONE 4'h0
`define CPS_F_OUV 4'h1
`define CPS_F_SOUV 4'h2
`define CPS_F_OOV 4'h3
`define CPS_F_DEMAG 4'h4
`define CPS_F_IUV 4'h5
`define CPS_F_IOV 4'h6
`define CPS_F_SUV 4'h7
`define CPS_F_PMIN 4'h8
`define CPS_F_PMAX 4'h9

`endif

// ### verilog/cps_supervisor.v
// Purpose: Protection supervisor of a flyback controller
// Assumes: Estimates and supply level arrive synchronous to I_MCLK
// Notes:   Time base is 1/64 of an operation cycle; APB slave
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.vh"

module cps_supervisor #(
    parameter P_OP_CYC_CLKS = `CPS_OP_CYC_NS / `CPS_CLK_NS
) (
    input wire I_MCLK,            // clock, 125 MHz
    input wire I_RST_N,           // sync reset, active low
    input wire I_CE,              // clock enable, freezes all
    input wire I_PSEL,            // APB select
    input wire I_PENABLE,         // APB enable
    input wire I_PWRITE,          // APB direction
    input wire [7:0] I_PADDR,     // APB address
    input wire [31:0] I_PWDATA,   // APB write data
    output reg [31:0] O_PRDATA,   // APB read data
    output reg O_PREADY,          // APB ready
    output reg O_PSLVERR,         // APB error, unmapped
    input wire [11:0] I_VOUT_EST, // estimated output voltage
    input wire [11:0] I_VIN_EST,  // estimated input voltage
    input wire [11:0] I_VCC_LVL,  // supply voltage code
    input wire [1:0] I_MODE,      // switching mode
    input wire I_DEMAG_SHORT,     // demag too short to sense
    input wire I_BURST_START,     // burst start pulse
    output reg O_GATE_EN,         // gate driver enable
    output reg [2:0] O_PHASE,     // supervisor phase
    output reg [3:0] O_FAULT_CODE // last triggered protection
);
    localparam [2:0] ST_LOCK = 3'b000;
    localparam [2:0] ST_PRE = 3'b001;
    localparam [2:0] ST_START = 3'b010;
    localparam [2:0] ST_REG = 3'b011;
    localparam [2:0] ST_RSTRT = 3'b100;
    localparam [2:0] ST_LATCH = 3'b101;
    localparam integer TICK_CLKS = P_OP_CYC_CLKS / `CPS_TICKS_PER_OP - 1;
    localparam [16:0] TICK_LAST = TICK_CLKS[16:0];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] ctrl_r, olvl_r, ilvl_r, slvl_r, vlvl_r, mlvl_r, tim0_r, tim1_r;
    reg [31:0] rd_nxt;
    reg map_nxt;
    wire wr_en = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;

    always @(*) begin
        map_nxt = 1'b1;
        case (I_PADDR)
            `CPS_A_CTRL: rd_nxt = ctrl_r;
            `CPS_A_OLVL: rd_nxt = olvl_r;
            `CPS_A_ILVL: rd_nxt = ilvl_r;
            `CPS_A_SLVL: rd_nxt = slvl_r;
            `CPS_A_VLVL: rd_nxt = vlvl_r;
            `CPS_A_MLVL: rd_nxt = mlvl_r;
            `CPS_A_TIM0: rd_nxt = tim0_r;
            `CPS_A_TIM1: rd_nxt = tim1_r;
            `CPS_A_STAT: rd_nxt = {20'h00000, O_FAULT_CODE, 3'h0, O_GATE_EN, 1'b0, O_PHASE};
            default: begin
                rd_nxt = 32'h0000_0000;
                map_nxt = 1'b0;
            end
        endcase
    end

    // Answer is always one access cycle: data is fetched in the setup cycle
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_PRDATA <= 32'h0000_0000;
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            ctrl_r <= `CPS_RST_VAL;
            olvl_r <= `CPS_RST_VAL;
            ilvl_r <= `CPS_RST_VAL;
            slvl_r <= `CPS_RST_VAL;
            vlvl_r <= `CPS_RST_VAL;
            mlvl_r <= `CPS_RST_VAL;
            tim0_r <= `CPS_RST_VAL;
            tim1_r <= `CPS_RST_VAL;
        end else if (I_CE) begin
            O_PREADY <= I_PSEL && !I_PENABLE;
            if (I_PSEL && !I_PENABLE) begin
                O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_nxt;
                O_PSLVERR <= !map_nxt;
            end else begin
                O_PSLVERR <= 1'b0;
            end
            if (wr_en) begin
                case (I_PADDR)
                    `CPS_A_CTRL: ctrl_r <= I_PWDATA & `CPS_CTRL_MASK;
                    `CPS_A_OLVL: olvl_r <= I_PWDATA & `CPS_LVL_MASK;
                    `CPS_A_ILVL: ilvl_r <= I_PWDATA & `CPS_LVL_MASK;
                    `CPS_A_SLVL: slvl_r <= I_PWDATA & `CPS_LVL_MASK;
                    `CPS_A_VLVL: vlvl_r <= I_PWDATA & `CPS_LVL_MASK;
                    `CPS_A_MLVL: mlvl_r <= I_PWDATA & `CPS_LVL_MASK;
                    `CPS_A_TIM0: tim0_r <= I_PWDATA;
                    `CPS_A_TIM1: tim1_r <= I_PWDATA & `CPS_T1_MASK;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    reg [16:0] div_r;
    reg [5:0] sub_r;
    wire tick = (div_r == TICK_LAST);
    wire op_tick = tick && (sub_r == `CPS_SUB_LAST);

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            div_r <= 17'h00000;
            sub_r <= 6'h00;
        end else if (I_CE) begin
            div_r <= tick ? 17'h00000 : div_r + 17'h00001;
            if (tick) begin
                sub_r <= sub_r + 6'h01;
            end
        end
    end

    // ----------------------------------------
    // Supply sampling and filter
    // ----------------------------------------
    reg [11:0] filt_r;
    wire [12:0] diff = {1'b0, I_VCC_LVL} - {1'b0, filt_r};
    wire [11:0] filt_nxt = filt_r + {diff[12], diff[12:2]};

    // Quarter-weight IIR; preloaded while locked so it starts settled
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            filt_r <= 12'h000;
        end else if (I_CE) begin
            if (O_PHASE == ST_LOCK) begin
                filt_r <= I_VCC_LVL;
            end else if (tick && O_GATE_EN) begin
                filt_r <= filt_nxt;
            end
        end
    end

    // ----------------------------------------
    // Fault conditions
    // ----------------------------------------
    wire burst = (I_MODE == `CPS_MODE_BURST);
    wire run = (O_PHASE == ST_REG);
    wire act = run || (O_PHASE == ST_START);
    wire in_ok = !burst || ctrl_r[`CPS_B_BIP_EN];
    wire c_ouv = run && ctrl_r[`CPS_B_OUV_EN] && (I_VOUT_EST < olvl_r[`CPS_LO]);
    wire c_oov = act && !burst && (I_VOUT_EST > olvl_r[`CPS_HI]);
    wire c_iuv = act && in_ok && ctrl_r[`CPS_B_IUV_EN] && (I_VIN_EST < ilvl_r[`CPS_LO]);
    wire c_iov = act && in_ok && ctrl_r[`CPS_B_IOV_EN] && (I_VIN_EST > ilvl_r[`CPS_HI]);
    wire c_suv = run && ctrl_r[`CPS_B_SUV_EN] && (filt_r < mlvl_r[`CPS_LO]);
    // Burst time base steps per burst, so blanking rounds to whole bursts
    wire in_step = burst ? I_BURST_START : tick;
    wire [15:0] iuv_lim = burst ? {8'h00, tim1_r[`CPS_T_B0]} : `CPS_IUV_TICKS;
    wire [15:0] iov_lim = burst ? {8'h00, tim1_r[`CPS_T_B1]} : `CPS_IOV_TICKS;
    wire [15:0] ouv_lim = {8'h00, tim0_r[`CPS_T_B0]} << `CPS_OP_SHIFT;
    wire [15:0] suv_lim = {8'h00, tim0_r[`CPS_T_B1]} << `CPS_OP_SHIFT;
    wire [15:0] st_lim = {8'h00, tim0_r[`CPS_T_B2]} * {8'h00, `CPS_START_PER_CAP};
    wire [15:0] rs_lim = {8'h00, tim0_r[`CPS_T_B3]};
    wire f_ouv, f_oov, f_iuv, f_iov, f_suv, f_st, f_rs;

    cps_blank u_ouv (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(c_ouv),
        .i_step(tick),
        .i_limit(ouv_lim),
        .o_fire(f_ouv)
    );
    cps_blank u_oov (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(c_oov),
        .i_step(tick),
        .i_limit(`CPS_OOV_TICKS),
        .o_fire(f_oov)
    );
    cps_blank u_iuv (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(c_iuv),
        .i_step(in_step),
        .i_limit(iuv_lim),
        .o_fire(f_iuv)
    );
    cps_blank u_iov (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(c_iov),
        .i_step(in_step),
        .i_limit(iov_lim),
        .o_fire(f_iov)
    );
    cps_blank u_suv (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(c_suv),
        .i_step(tick),
        .i_limit(suv_lim),
        .o_fire(f_suv)
    );
    cps_blank u_st (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(O_PHASE == ST_START),
        .i_step(op_tick),
        .i_limit(st_lim),
        .o_fire(f_st)
    );
    cps_blank u_rs (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_cond(O_PHASE == ST_RSTRT),
        .i_step(op_tick),
        .i_limit(rs_lim),
        .o_fire(f_rs)
    );

    // Demag shortage is counted per operation cycle, not continuously
    reg [6:0] dm_r;
    wire f_dm = (dm_r > `CPS_DEMAG_TICKS);

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            dm_r <= 7'h00;
        end else if (I_CE) begin
            if (!act || burst || op_tick) begin
                dm_r <= 7'h00;
            end else if (tick && I_DEMAG_SHORT) begin
                dm_r <= dm_r + 7'h01;
            end
        end
    end

    // ----------------------------------------
    // Fault priority and reaction
    // ----------------------------------------
    reg [3:0] code;
    reg latch;
    wire st_low = I_VOUT_EST < mlvl_r[`CPS_HI];

    always @(*) begin
        code = `CPS_F_NONE;
        latch = 1'b0;
        if (f_oov) begin
            code = `CPS_F_OOV;
            latch = ctrl_r[`CPS_B_OOV_LAT];
        end else if (f_ouv) begin
            code = `CPS_F_OUV;
            latch = ctrl_r[`CPS_B_OUV_LAT];
        end else if (f_iov) begin
            code = `CPS_F_IOV;
        end else if (f_iuv) begin
            code = `CPS_F_IUV;
        end else if (f_suv) begin
            code = `CPS_F_SUV;
        end else if (f_dm) begin
            code = `CPS_F_DEMAG;
        end else if (f_st && st_low) begin
            code = `CPS_F_SOUV;
        end
    end

    // ----------------------------------------
    // Phase machine
    // ----------------------------------------
    reg [2:0] ph_nxt;
    reg [3:0] fc_nxt;

    always @(*) begin
        ph_nxt = O_PHASE;
        fc_nxt = O_FAULT_CODE;
        case (O_PHASE)
            ST_LOCK: begin
                if (I_VCC_LVL > vlvl_r[`CPS_LO]) begin
                    ph_nxt = ST_PRE;
                end
            end
            ST_PRE: begin
                if (ctrl_r[`CPS_B_IUV_EN] && (I_VIN_EST < slvl_r[`CPS_LO])) begin
                    ph_nxt = ST_RSTRT;
                    fc_nxt = `CPS_F_PMIN;
                end else if (ctrl_r[`CPS_B_IOV_EN] && (I_VIN_EST > slvl_r[`CPS_HI])) begin
                    ph_nxt = ST_RSTRT;
                    fc_nxt = `CPS_F_PMAX;
                end else begin
                    ph_nxt = ST_START;
                end
            end
            ST_START, ST_REG: begin
                if (code != `CPS_F_NONE) begin
                    ph_nxt = latch ? ST_LATCH : ST_RSTRT;
                    fc_nxt = code;
                end else if ((O_PHASE == ST_START) && !st_low) begin
                    ph_nxt = ST_REG;
                end else if (f_st) begin
                    ph_nxt = ST_REG;
                end
            end
            ST_RSTRT: begin
                if (f_rs) begin
                    ph_nxt = ST_PRE;
                end
            end
            ST_LATCH: ph_nxt = ST_LATCH;
            default: ph_nxt = ST_LOCK;
        endcase
        // Supply drop overrides every phase, latch included
        if ((O_PHASE != ST_LOCK) && (I_VCC_LVL <= vlvl_r[`CPS_HI])) begin
            ph_nxt = ST_LOCK;
        end
    end

    // Gate follows the next phase, so a fault drops it in the same clock as the phase changes
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_PHASE <= ST_LOCK;
            O_FAULT_CODE <= `CPS_F_NONE;
            O_GATE_EN <= 1'b0;
        end else if (I_CE) begin
            O_PHASE <= ph_nxt;
            O_FAULT_CODE <= fc_nxt;
            O_GATE_EN <= (ph_nxt == ST_START) || (ph_nxt == ST_REG);
        end
    end
endmodule // cps_supervisor
`default_nettype wire
